// [rtl/pwm_sync_params.svh]
// Purpose: Register map, field positions, reset values and ratios of the PWM sync block
// Assumes: APB word registers, byte addresses below
// Notes:   Definitions only
`ifndef PWM_SYNC_PARAMS_SVH
`define PWM_SYNC_PARAMS_SVH

// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_SYNC      8'h04
`define OFS_OUTMASK   8'h08
`define OFS_CNTIN     8'h0C
`define OFS_MOD       8'h10
`define OFS_DEADTIME  8'h14
`define OFS_POL       8'h18
`define OFS_COUNT     8'h1C
`define OFS_CV_BASE   8'h20

// Control register bits
`define CTRL_MASK_SYNC 0
`define CTRL_ON_TRIGGER_A    1
`define CTRL_MAX_SEL   2
`define CTRL_MIN_SEL   3
`define CTRL_SYNC_EN   4

// Sync register bits
`define SYNC_SW        0
`define SYNC_HW_LSB    1

// Deadtime register fields
`define DT_VAL_LSB     0
`define DT_PS_LSB      6
`define DT_EN_BIT      8

// Reset values
`define MOD_RST        16'hFFFF

// Deadtime prescale ratios minus one
`define DT_DIV1_M1     4'h0
`define DT_DIV4_M1     4'h3
`define DT_DIV16_M1    4'hF

`endif

// [rtl/pwm_sync_pkg.sv]
// Purpose: Shared types of the PWM sync block
// Assumes: Constants live in pwm_sync_params.svh
// Notes:   None
package pwm_sync_pkg;
   typedef enum logic [1:0] {
      DT_PS_DIV1A = 2'h0,
      DT_PS_DIV1B = 2'h1,
      DT_PS_DIV4  = 2'h2,
      DT_PS_DIV16 = 2'h3
   } dt_ps_e;
   typedef logic [31:0] word_t;
endpackage : pwm_sync_pkg

// [rtl/pwm_sync_deadtime.sv]
// Purpose: PWM counter, buffered register synchronisation and deadtime insertion
// Assumes: APB slave with zero wait states; trigger inputs synchronised here
// Notes:   Channels are combined in pairs, even channel active between its two values
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "pwm_sync_params.svh"

// How it works
// - Output-mask writes go to a buffer; live mask loads from it later.
// - Mask-sync-select 0: live mask follows buffer every clock.
// - Mask-sync-select 1: live mask loads at the next enabled trigger event.
// - Mask sync with select 1 and on_trigger_a 0 clears the trigger bit at the selected boundary.
// - Counter sync loads initial value; an on_trigger_a trigger also reloads the deadtime delay of every pair.
// - On_trigger_a 0: counter sync only at wrap from modulo to initial value.
// - On_trigger_a 1: counter forced to initial value at trigger, trigger bit cleared.
// - New initial value shows after next overflow or on_trigger_a trigger.
// - On_trigger_a 0: modulo and channel values load at selected boundary after trigger.
// - On_trigger_a 1: modulo and channel values load immediately at the trigger.
// - Trigger bit cleared at boundary (on_trigger_a 0) or at trigger (on_trigger_a 1).
// - Deadtime active only when enabled and count field non-zero.
// - One deadtime for all pairs: count times prescaled clock period.
// - Complementary outputs never both active while deadtime is enabled.
// - Polarity 0: rising edges of either channel delayed by deadtime.
// - Polarity 1: falling edges of either channel delayed by deadtime.
// - Deadtime not below even duty keeps even output inactive.
// - Deadtime not below odd duty keeps odd output inactive.
// - Hardware trigger is synchronised rising edge on an enabled input.
// - Writing 1 to software sync triggers; set wins over hardware clear.
// - Both selects: first boundary wins; neither: no update without on_trigger_a.
module pwm_sync_deadtime
   import pwm_sync_pkg::*;
#(
   parameter int NPAIR = 2,
   parameter int CW    = 16
) (
   // Clock and reset
   input  wire logic                 CLK_SYS,
   input  wire logic                 ARST_N,
   // APB slave
   input  wire logic                 PSEL,
   input  wire logic                 PENABLE,
   input  wire logic                 PWRITE,
   input  wire logic [7:0]           PADDR,
   input  wire logic [31:0]          PWDATA,
   output logic      [31:0]          PRDATA,
   output logic                      PREADY,
   output logic                      PSLVERR,
   // Hardware triggers and channel outputs
   input  wire logic [2:0]           TRIG_IN,
   output logic      [2*NPAIR-1:0]   PWM_OUT
);
   localparam int NCH = 2 * NPAIR;

   typedef struct packed {
      logic [2:0]                trig_s1;
      logic [2:0]                trig_s2;
      logic [2:0]                trig_s3;
      logic                      mask_sync;
      logic                      on_trigger_a;
      logic                      max_sel;
      logic                      min_sel;
      logic                      sync_en;
      logic                      sw_bit;
      logic                      sw_go;
      logic [2:0]                hw_en;
      logic                      pend_sw;
      logic [2:0]                pend_hw;
      logic [NCH-1:0]            mask_buf;
      logic [NCH-1:0]            mask;
      logic [CW-1:0]             cntin_buf;
      logic [CW-1:0]             cntin;
      logic [CW-1:0]             mod_buf;
      logic [CW-1:0]             mod;
      logic [CW-1:0]             cnt;
      logic [NCH-1:0][CW-1:0]    cv_buf;
      logic [NCH-1:0][CW-1:0]    cv;
      logic [5:0]                dt_val;
      logic [1:0]                dt_ps;
      logic                      dt_en;
      logic [NCH-1:0]            pol;
      logic [NPAIR-1:0]          ref_q;
      logic [NPAIR-1:0][9:0]     dt_cnt;
      logic [NCH-1:0]            out;
   } state_s;

   state_s            r_reg;
   state_s            r_next;
   logic [1:0]        rst_sync_reg;
   logic              rst_n;
   logic [NPAIR-1:0]  pair_ref;
   logic              wr;
   logic              wr_sync;
   logic [2:0]        hw_evt;
   logic              trig_evt;
   logic              wrap;
   logic              boundary;
   logic              dt_on;
   logic [9:0]        dt_len;
   logic              cv_sel;
   logic [2:0]        cv_idx;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////////////
   // Pair reference: even channel active between its value and the odd value
   genvar gp;
   generate
      for (gp = 0; gp < NPAIR; gp++) begin : g_pair
         assign pair_ref[gp] = (r_reg.cnt >= r_reg.cv[2*gp]) &&
                               (r_reg.cnt < r_reg.cv[2*gp+1]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode and events
   assign wr       = PSEL && PENABLE && PWRITE;
   assign wr_sync  = wr && (PADDR == `OFS_SYNC);
   assign cv_sel   = (PADDR[7:5] == 3'h1) && (int'(PADDR[4:2]) < NCH);
   assign cv_idx   = PADDR[4:2];
   assign hw_evt   = r_reg.trig_s2 & ~r_reg.trig_s3 & r_reg.hw_en;
   assign trig_evt = r_reg.sw_go || (|hw_evt);
   assign wrap     = (r_reg.cnt >= r_reg.mod);
   assign boundary = (r_reg.max_sel && (r_reg.cnt == CW'(r_reg.mod - 1'b1))) ||
                     (r_reg.min_sel && wrap);
   assign dt_on    = r_reg.dt_en && (r_reg.dt_val != 6'h0);
   assign PREADY   = 1'b1;
   assign PWM_OUT  = r_reg.out;

   always_comb begin
      PRDATA  = 32'h0;
      PSLVERR = 1'b0;
      case (PADDR)
         `OFS_CTRL:     PRDATA[4:0] = {r_reg.sync_en, r_reg.min_sel, r_reg.max_sel,
                                       r_reg.on_trigger_a, r_reg.mask_sync};
         `OFS_SYNC:     PRDATA[3:0] = {r_reg.hw_en, r_reg.sw_bit};
         `OFS_OUTMASK:  PRDATA[NCH-1:0] = r_reg.mask;
         `OFS_CNTIN:    PRDATA[CW-1:0] = r_reg.cntin;
         `OFS_MOD:      PRDATA[CW-1:0] = r_reg.mod;
         `OFS_DEADTIME: PRDATA[8:0] = {r_reg.dt_en, r_reg.dt_ps, r_reg.dt_val};
         `OFS_POL:      PRDATA[NCH-1:0] = r_reg.pol;
         `OFS_COUNT:    PRDATA[CW-1:0] = r_reg.cnt;
         default: begin
            if (cv_sel) begin
               PRDATA[CW-1:0] = r_reg.cv[cv_idx];
            end else begin
               PSLVERR = PSEL && PENABLE;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic dt_done;
      logic even_act;
      logic odd_act;
      logic restart;
      dt_done  = 1'b0;
      even_act = 1'b0;
      odd_act  = 1'b0;
      restart  = 1'b0;
      r_next = r_reg;
      r_next.trig_s1 = TRIG_IN;
      r_next.trig_s2 = r_reg.trig_s1;
      r_next.trig_s3 = r_reg.trig_s2;
      r_next.sw_go   = 1'b0;

      // Free counting with wrap to the initial value
      if (wrap) begin
         r_next.cnt   = r_reg.cntin;
         r_next.cntin = r_reg.cntin_buf;
      end else begin
         r_next.cnt = CW'(r_reg.cnt + 1'b1);
      end

      if (!r_reg.mask_sync) begin
         r_next.mask = r_reg.mask_buf;
      end

      // Pending sync completes at the selected boundary
      if (!r_reg.on_trigger_a && boundary && (r_reg.pend_sw || (|r_reg.pend_hw))) begin
         r_next.mod = r_reg.mod_buf;
         if (r_reg.sync_en) begin
            r_next.cv = r_reg.cv_buf;
         end
         if (r_reg.pend_sw) begin
            r_next.sw_bit = 1'b0;
         end
         r_next.hw_en   = r_next.hw_en & ~r_reg.pend_hw;
         r_next.pend_sw = 1'b0;
         r_next.pend_hw = 3'h0;
      end

      if (trig_evt) begin
         if (r_reg.mask_sync) begin
            r_next.mask = r_reg.mask_buf;
         end
         if (r_reg.on_trigger_a) begin
            r_next.cnt   = r_reg.cntin_buf;
            r_next.cntin = r_reg.cntin_buf;
            r_next.mod   = r_reg.mod_buf;
            if (r_reg.sync_en) begin
               r_next.cv = r_reg.cv_buf;
            end
            if (r_reg.sw_go) begin
               r_next.sw_bit = 1'b0;
            end
            r_next.hw_en = r_next.hw_en & ~hw_evt;
            restart      = 1'b1;
         end else begin
            r_next.pend_sw = r_next.pend_sw | r_reg.sw_go;
            r_next.pend_hw = r_next.pend_hw | hw_evt;
         end
      end

      // Register writes come last so a set wins over a hardware clear
      if (wr) begin
         case (PADDR)
            `OFS_CTRL: begin
               r_next.mask_sync = PWDATA[`CTRL_MASK_SYNC];
               r_next.on_trigger_a    = PWDATA[`CTRL_ON_TRIGGER_A];
               r_next.max_sel   = PWDATA[`CTRL_MAX_SEL];
               r_next.min_sel   = PWDATA[`CTRL_MIN_SEL];
               r_next.sync_en   = PWDATA[`CTRL_SYNC_EN];
            end
            `OFS_SYNC: begin
               r_next.sw_bit = PWDATA[`SYNC_SW];
               r_next.sw_go  = PWDATA[`SYNC_SW];
               r_next.hw_en  = PWDATA[`SYNC_HW_LSB +: 3];
               // A bit cleared by software also drops its pending boundary sync
               r_next.pend_sw = r_next.pend_sw & PWDATA[`SYNC_SW];
               r_next.pend_hw = r_next.pend_hw & PWDATA[`SYNC_HW_LSB +: 3];
            end
            `OFS_OUTMASK:  r_next.mask_buf  = PWDATA[NCH-1:0];
            `OFS_CNTIN:    r_next.cntin_buf = PWDATA[CW-1:0];
            `OFS_MOD:      r_next.mod_buf   = PWDATA[CW-1:0];
            `OFS_DEADTIME: begin
               r_next.dt_val = PWDATA[`DT_VAL_LSB +: 6];
               r_next.dt_ps  = PWDATA[`DT_PS_LSB +: 2];
               r_next.dt_en  = PWDATA[`DT_EN_BIT];
            end
            `OFS_POL:      r_next.pol = PWDATA[NCH-1:0];
            default: begin
               if (cv_sel) begin
                  r_next.cv_buf[cv_idx] = PWDATA[CW-1:0];
               end
            end
         endcase
      end

      // Shared deadtime length in system clocks: count times prescale ratio
      // A free running prescaler would shorten the delay by up to one ratio
      case (dt_ps_e'(r_reg.dt_ps))
         DT_PS_DIV4: begin
            dt_len = 10'(r_reg.dt_val) * (10'(`DT_DIV4_M1) + 10'h1);
         end
         DT_PS_DIV16: begin
            dt_len = 10'(r_reg.dt_val) * (10'(`DT_DIV16_M1) + 10'h1);
         end
         default: begin
            dt_len = 10'(r_reg.dt_val) * (10'(`DT_DIV1_M1) + 10'h1);
         end
      endcase

      // Per pair deadtime and output stage
      for (int p = 0; p < NPAIR; p++) begin
         r_next.ref_q[p] = pair_ref[p];
         // Every reference edge reloads the full delay
         if ((pair_ref[p] != r_reg.ref_q[p]) || restart) begin
            r_next.dt_cnt[p] = dt_len;
         end else if (r_reg.dt_cnt[p] != 10'h0) begin
            r_next.dt_cnt[p] = 10'(r_reg.dt_cnt[p] - 1'b1);
         end
         dt_done  = !dt_on || (r_reg.dt_cnt[p] == 10'h0);
         even_act = r_reg.ref_q[p] && dt_done;
         odd_act  = !r_reg.ref_q[p] && dt_done;
         r_next.out[2*p]   = r_reg.mask[2*p]   ? r_reg.pol[2*p] :
                             (even_act ^ r_reg.pol[2*p]);
         r_next.out[2*p+1] = r_reg.mask[2*p+1] ? r_reg.pol[2*p+1] :
                             (odd_act ^ r_reg.pol[2*p+1]);
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         r_reg         <= '0;
         r_reg.mod     <= `MOD_RST;
         r_reg.mod_buf <= `MOD_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!rst_n);

   a_mask_direct: assert property (
      !r_reg.mask_sync |=> r_reg.mask == $past(r_reg.mask_buf))
      else $error("live mask did not follow its buffer");
   a_mask_hold: assert property (
      (r_reg.mask_sync && !trig_evt) |=> r_reg.mask == $past(r_reg.mask))
      else $error("mask changed without a trigger");
   a_wrap_load: assert property (
      (wrap && !trig_evt) |=> r_reg.cnt == $past(r_reg.cntin))
      else $error("counter did not wrap to initial value");
   a_on_trigger_a_load: assert property (
      (trig_evt && r_reg.on_trigger_a) |=>
      (r_reg.cnt == $past(r_reg.cntin_buf)) && (r_reg.mod == $past(r_reg.mod_buf)))
      else $error("on_trigger_a trigger did not load counter and modulo");
   a_sw_clear: assert property (
      (r_reg.sw_go && r_reg.on_trigger_a && !wr_sync) |=> !r_reg.sw_bit)
      else $error("software sync bit not cleared at trigger");
   a_hw_clear_bnd: assert property (
      (boundary && !r_reg.on_trigger_a && (|r_reg.pend_hw) && !wr_sync) |=>
      (r_reg.hw_en & $past(r_reg.pend_hw)) == 3'h0)
      else $error("hardware trigger enable not cleared at boundary");
   a_no_boundary: assert property (
      (!r_reg.on_trigger_a && !r_reg.max_sel && !r_reg.min_sel) |=> r_reg.mod == $past(r_reg.mod))
      else $error("modulo updated with no boundary selected");
   a_cv_hold: assert property (
      !r_reg.sync_en |=> r_reg.cv == $past(r_reg.cv))
      else $error("channel values loaded with sync disabled");
   // Outputs are registered, so they carry the polarity of the cycle before
   a_dt_exclusive: assert property (
      dt_on |-> !((r_reg.out[0] ^ $past(r_reg.pol[0])) && (r_reg.out[1] ^ $past(r_reg.pol[1]))))
      else $error("both outputs of pair 0 active");
   // The delay loaded at a reference edge comes from the count of the cycle before
   a_dt_hold: assert property (
      (dt_on && ($past(r_reg.dt_val) != 6'h0) && $changed(r_reg.ref_q[0]) &&
       !(|r_reg.mask[1:0])) |=>
      (r_reg.out[0] == $past(r_reg.pol[0])) && (r_reg.out[1] == $past(r_reg.pol[1])))
      else $error("output edge not delayed by deadtime");
endmodule : pwm_sync_deadtime

// [tb/pwm_sync_deadtime_bench.sv]
// Purpose: Self-checking bench for the PWM sync and deadtime block
// Assumes: Zero-wait APB slave at the offsets of pwm_sync_params.svh
// Notes:   Expected values come from a small integer model kept in this bench
`timescale 1ns/1ps
`include "pwm_sync_params.svh"

module pwm_sync_deadtime_bench
   import pwm_sync_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        arst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   word_t       pwdata;
   word_t       prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  trig_in;
   logic [3:0]  pwm_out;
   logic [3:0]  act;
   word_t       rd;
   logic        er;
   int          miscompares = 0;
   int          checks_done = 0;
   integer      seed = 32'h694d;
   int          mod_live;
   int          cv1_live;
   int          nv;
   int          dt;
   int          lap;
   int          ev;
   int          od;
   int          a0;
   int          a1;
   int          ovl;
   int          p1;
   int          dtq[$] = '{32'h005, 32'h100, 32'h105, 32'h145, 32'h185, 32'h1C5};

   always #5 clk_sys = ~clk_sys;

   pwm_sync_deadtime #(.NPAIR(2), .CW(16)) dut (
      .CLK_SYS (clk_sys), .ARST_N (arst_n), .PSEL (psel), .PENABLE (penable),
      .PWRITE (pwrite), .PADDR (paddr), .PWDATA (pwdata), .PRDATA (prdata),
      .PREADY (pready), .PSLVERR (pslverr), .TRIG_IN (trig_in), .PWM_OUT (pwm_out));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input word_t seen, input word_t exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input word_t d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) begin
         @(posedge clk_sys);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input int d);
      apb(1'b1, a, word_t'(d));
   endtask : wr

   task automatic rdc(input logic [7:0] a, input int exp);
      apb(1'b0, a, 32'h0);
      chk(rd, word_t'(exp));
   endtask : rdc

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc

   task automatic trig(input int b);
      @(posedge clk_sys);
      trig_in <= 3'h1 << b;
      cyc(3);
      trig_in <= 3'h0;
   endtask : trig

   task complete_run;
      $display("Checks done %0d, miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      complete_run();
   end

   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      trig_in = 3'h0;
      cyc(12);
      arst_n <= 1'b1;
      cyc(3);
      // Reset values and an unmapped address
      rdc(`OFS_CTRL, 0);
      rdc(`OFS_MOD, 32'hFFFF);
      apb(1'b0, 8'h40, 32'h0);
      chk(word_t'(er), 32'h1);
      chk(rd, 32'h0);
      chk(word_t'(pready), 32'h1);
      // Mask follows its buffer, then waits for a trigger
      wr(`OFS_OUTMASK, 5);
      rdc(`OFS_OUTMASK, 5);
      wr(`OFS_CTRL, 1);
      wr(`OFS_OUTMASK, 10);
      rdc(`OFS_OUTMASK, 5);
      wr(`OFS_SYNC, 1);
      cyc(4);
      rdc(`OFS_OUTMASK, 10);
      rdc(`OFS_SYNC, 1);
      wr(`OFS_SYNC, 0);
      wr(`OFS_CTRL, 0);
      wr(`OFS_OUTMASK, 0);
      // Immediate load on a software trigger
      wr(`OFS_CTRL, 32'h12);
      wr(`OFS_CNTIN, 0);
      mod_live = 100 + ($random(seed) & 63);
      wr(`OFS_MOD, mod_live);
      nv = $random(seed) & 31;
      wr(`OFS_CV_BASE, nv);
      wr(`OFS_SYNC, 1);
      cyc(2);
      rdc(`OFS_MOD, mod_live);
      rdc(`OFS_CV_BASE, nv);
      rdc(`OFS_SYNC, 0);
      apb(1'b0, `OFS_COUNT, 32'h0);
      chk(word_t'(rd < 32'd20), 32'h1);
      // Boundary loads: max, min, both
      cv1_live = 0;
      for (int s = 1; s < 4; s++) begin
         wr(`OFS_CTRL, s * 4);
         nv = 100 + ($random(seed) & 63);
         wr(`OFS_MOD, nv);
         wr(`OFS_CV_BASE + 8'h4, 77);
         cyc(200);
         rdc(`OFS_MOD, mod_live);
         wr(`OFS_SYNC, 1);
         cyc(200);
         mod_live = nv;
         rdc(`OFS_MOD, mod_live);
         rdc(`OFS_SYNC, 0);
         rdc(`OFS_CV_BASE + 8'h4, cv1_live);
      end
      // Hardware triggers, each enabled alone
      wr(`OFS_CTRL, 2);
      for (int t = 0; t < 3; t++) begin
         nv = 100 + ($random(seed) & 63);
         wr(`OFS_MOD, nv);
         wr(`OFS_SYNC, 2 << t);
         trig((t + 1) % 3);
         cyc(6);
         rdc(`OFS_MOD, mod_live);
         trig(t);
         cyc(6);
         mod_live = nv;
         rdc(`OFS_MOD, mod_live);
         rdc(`OFS_SYNC, 0);
      end
      // Deadtime on pair 0: period 100, even reference 40 cycles
      wr(`OFS_CTRL, 32'h12);
      wr(`OFS_MOD, 99);
      wr(`OFS_CV_BASE, 20);
      wr(`OFS_CV_BASE + 8'h4, 60);
      wr(`OFS_SYNC, 1);
      for (int i = 0; i < 7; i++) begin
         dt = (i < 6) ? dtq[i] : 32'h105;
         wr(`OFS_POL, (i == 6) ? 3 : 0);
         wr(`OFS_DEADTIME, dt);
         ev = 40;
         od = 60;
         if (((dt >> 8) & 1) == 1 && (dt & 63) != 0) begin
            lap = (dt >> 6) & 3;
            lap = (dt & 63) * ((lap == 2) ? 4 : (lap == 3) ? 16 : 1);
            ev = (lap >= 40) ? 0 : 40 - lap;
            od = (lap >= 60) ? 0 : 60 - lap;
         end
         cyc(200);
         a0 = 0;
         a1 = 0;
         ovl = 0;
         p1 = 0;
         repeat (100) begin
            @(negedge clk_sys);
            act = pwm_out ^ ((i == 6) ? 4'h3 : 4'h0);
            a0 += int'(act[0] === 1'b1);
            a1 += int'(act[1] === 1'b1);
            ovl += int'(act[0] !== 1'b0 && act[1] !== 1'b0);
            p1 += int'(act[3:2] === 2'b10);
         end
         chk(word_t'(p1), 32'd100);
         chk(word_t'(a0), word_t'(ev));
         chk(word_t'(a1), word_t'(od));
         chk(word_t'(ovl), 32'h0);
      end
      // Wrap stays in range, new initial value shows after overflow
      apb(1'b0, `OFS_COUNT, 32'h0);
      chk(word_t'(rd <= 32'd99), 32'h1);
      wr(`OFS_CTRL, 4);
      wr(`OFS_CNTIN, 10);
      cyc(120);
      apb(1'b0, `OFS_COUNT, 32'h0);
      chk(word_t'(rd >= 32'd10 && rd <= 32'd99), 32'h1);
      rdc(`OFS_CNTIN, 10);
      complete_run();
   end
endmodule : pwm_sync_deadtime_bench
